//--- lictl_pkg.sv
// constants for the line interface control register bank
package lictl_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [13:0] IDX_LINE_TXRX_CONTROL = 14'h1000;
  localparam logic [13:0] IDX_TX_IMPEDANCE_PULSE_SHAPE = 14'h1001;
  localparam logic [13:0] IDX_LINE_MAINTENANCE_CONTROL = 14'h1002;
  localparam logic [13:0] IDX_LINE_REALTIME_STATUS = 14'h1003;
  localparam logic [13:0] IDX_LINE_STATUS_INTERRUPT_MASK = 14'h1004;
  localparam logic [13:0] IDX_LINE_LATCHED_STATUS = 14'h1005;
  localparam logic [13:0] IDX_RX_SIGNAL_LEVEL = 14'h1006;
  localparam logic [13:0] IDX_RX_IMPEDANCE_SENSITIVITY = 14'h1007;
  localparam logic [13:0] IDX_RESERVED_FIRST = 14'h1008;
  localparam logic [13:0] IDX_RESERVED_LAST = 14'h101F;
  // reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // writable bit masks; other bits read as zero
  localparam logic [7:0] MASK_TXRX = 8'h1F;
  localparam logic [7:0] MASK_TXIMP = 8'h77;
  // line_txrx_control fields
  localparam int B_JA_DEPTH = 4;
  localparam int B_JA_POS_HI = 3;
  localparam int B_JA_POS_LO = 2;
  localparam int B_LINE_STD = 1;
  localparam int B_LOS_CRIT = 0;
  // tx_impedance_pulse_shape fields
  localparam int B_TERM_OFF = 6;
  localparam int B_IMPL_HI = 5;
  localparam int B_IMPL_LO = 4;
  localparam int B_LBO_HI = 2;
  // line_maintenance_control fields
  localparam int B_FORCE_AIS = 7;
  localparam int B_AUTO_AIS = 6;
  localparam int B_NEAR_LB = 5;
  localparam int B_ANALOG_LB = 4;
  localparam int B_FAR_LB = 3;
  localparam int B_TX_PD = 2;
  localparam int B_RX_PD = 1;
  localparam int B_DRV_ON = 0;
  // jitter attenuator settings
  localparam logic [7:0] JA_DEPTH_DEEP = 8'h80;
  localparam logic [7:0] JA_DEPTH_SHALLOW = 8'h20;
  localparam logic [1:0] JA_POS_RX = 2'h0;
  localparam logic [1:0] JA_POS_TX = 2'h1;
  // loss-of-signal criterion codes driven to the receiver
  localparam logic [1:0] LOS_G775 = 2'h0;
  localparam logic [1:0] LOS_ETS300233 = 2'h1;
  localparam logic [1:0] LOS_T1231 = 2'h2;
  // first build-out code that selects a csu attenuation in t1/j1 mode
  localparam logic [2:0] LBO_CSU_FIRST = 3'h5;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {SEL_REG, SEL_RESERVED, SEL_NONE} lictl_sel_type;
endpackage

//--- lictl_regs.sv
// axi4-lite register bank controlling one channel of the line interface
// Operation
// - Depth bit: 128 bits clear, 32 set
// - Position code: 00 rx, 01 tx, else bypass
// - Standard bit: 0 E1, 1 T1 or J1
// - Criterion bit picks loss rule; T1 fixed
// - Termination-off bit disables internal tx termination
// - Load impedance code: 75, 100, 110, 120 ohm
// - Build-out code sets waveshape per line standard
// - T1 codes 101 to 111 select CSU
// - Force bit sends all-ones, framer data ignored
// - Auto bit sends all-ones on signal loss
// - Near and analog loopback follow their bits
// - Far loopback returns receive data to transmit
// - Transmit power-down floats the line outputs
// - Receive power-down bit powers receiver down
// - Drive bit enables outputs; pin overrides it
// - Status bits 5,4: over, under equalized
// - Status bit 2: transmit outputs shorted
// - Status bit 1: transmit outputs open
// - Status bit 0: loss of signal
// - Mask bit one lets its event interrupt
// - Events latch on detection and on removal; open, short detection not latched in CSU mode
//
// The AXI4-Lite slave port is this design's own decision.
module lictl_regs
  import lictl_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input wire logic aclk, // system clock, 25 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic los_det, // receiver reports loss of signal
  input wire logic tx_open_det, // transmit outputs open
  input wire logic tx_short_det, // transmit outputs shorted
  input wire logic equalizer_over, // equalizer over equalized
  input wire logic equalizer_under, // equalizer under equalized
  input wire logic ja_limit_trip, // jitter attenuator limit trip
  input wire logic [3:0] rx_level, // receive signal level code
  input wire logic tx_enable_pin, // external transmit enable pin
  input wire logic framer_tx_data, // transmit data from framer
  input wire logic rx_line_data, // recovered receive line data
  output logic [7:0] jitter_fifo_depth, // attenuator depth in bits
  output logic ja_in_rx_path, // attenuator in receive path
  output logic ja_in_tx_path, // attenuator in transmit path
  output logic line_standard_sel, // 0 e1, 1 t1 or j1
  output logic [1:0] signal_absence_criterion, // los criterion code
  output logic tx_termination_on, // internal tx termination on
  output logic [1:0] tx_load_impedance, // 75/100/110/120 ohm code
  output logic [3:0] tx_waveshape, // line standard and build-out code
  output logic tx_csu_mode, // t1 csu attenuation selected
  output logic tx_alarm_active, // all-ones alarm being sent
  output logic tx_line_data, // data to the line driver
  output logic near_loopback_en, // local loopback
  output logic analog_loopback_en, // analog loopback
  output logic far_loopback_en, // remote loopback
  output logic tx_powerdown, // transmitter powered down
  output logic rx_powerdown, // receiver powered down
  output logic tx_line_oe, // transmit line outputs driven
  output logic [3:0] rx_impedance_cfg, // receive impedance bits
  output logic [3:0] rx_sensitivity_cfg, // receive sensitivity bits
  output logic irq // interrupt request, active high
);

  // ---------------- bus slave ----------------
  function automatic lictl_sel_type decode(input logic [ADDR_W-1:0] addr);
    logic [13:0] idx;
    idx = 14'(addr >> 2);
    if (idx >= IDX_LINE_TXRX_CONTROL && idx <= IDX_RX_IMPEDANCE_SENSITIVITY) begin
      return SEL_REG;
    end else if (idx >= IDX_RESERVED_FIRST && idx <= IDX_RESERVED_LAST) begin
      return SEL_RESERVED;
    end
    return SEL_NONE;
  endfunction

  logic aw_hold_q, w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wen_q;
  logic bvalid_q, rvalid_q, awready_q, wready_q, arready_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  wire aw_fire = s_axi_awvalid & awready_q;
  wire w_fire = s_axi_wvalid & wready_q;
  wire do_write = aw_hold_q & w_hold_q & ~bvalid_q;
  wire aw_hold_d = (aw_hold_q | aw_fire) & ~do_write;
  wire w_hold_d = (w_hold_q | w_fire) & ~do_write;
  wire bvalid_d = (bvalid_q & ~s_axi_bready) | do_write;
  lictl_sel_type wsel;
  assign wsel = decode(awaddr_q);
  wire [2:0] woff = awaddr_q[4:2];
  wire wr_reg = do_write & wen_q & (wsel == SEL_REG);
  wire ar_fire = s_axi_arvalid & arready_q;
  lictl_sel_type rsel;
  assign rsel = decode(s_axi_araddr);
  wire [2:0] roff = s_axi_araddr[4:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= RST_REG;
      wen_q <= 1'b0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= ~aw_hold_d;
      wready_q <= ~w_hold_d;
      bvalid_q <= bvalid_d;
      if (aw_fire) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        wbyte_q <= s_axi_wdata[7:0];
        wen_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        bresp_q <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // ---------------- pin synchronisers ----------------
  localparam int NSYNC = 11;
  wire [NSYNC-1:0] raw_in = {rx_level, tx_enable_pin, ja_limit_trip, equalizer_over,
                             equalizer_under, tx_short_det, tx_open_det, los_det};
  logic [NSYNC-1:0] sync1_q, sync2_q;
  logic [3:0] cond_prev_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      cond_prev_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      cond_prev_q <= {sync2_q[5], sync2_q[1], sync2_q[2], sync2_q[0]};
    end
  end

  wire los_s = sync2_q[0];
  wire open_s = sync2_q[1];
  wire short_s = sync2_q[2];
  wire under_s = sync2_q[3];
  wire over_s = sync2_q[4];
  wire jalt_s = sync2_q[5];
  wire txen_pin_s = sync2_q[6];
  wire [3:0] level_s = sync2_q[10:7];

  // ---------------- control registers ----------------
  logic [7:0] txrx_q, timp_q, maint_q, mask_q, rxcfg_q, latched_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txrx_q <= RST_REG;
      timp_q <= RST_REG;
      maint_q <= RST_REG;
      mask_q <= RST_REG;
      rxcfg_q <= RST_REG;
    end else if (wr_reg) begin
      case (woff)
        3'h0: txrx_q <= wbyte_q & MASK_TXRX;
        3'h1: timp_q <= wbyte_q & MASK_TXIMP;
        3'h2: maint_q <= wbyte_q;
        3'h4: mask_q <= wbyte_q;
        3'h7: rxcfg_q <= wbyte_q;
        default: ;
      endcase
    end
  end

  // ---------------- latched status ----------------
  // latched order is jalt, open, short, los: open detect sits above short detect
  wire [3:0] cond_now = {jalt_s, open_s, short_s, los_s};
  wire [3:0] rise = cond_now & ~cond_prev_q;
  wire [3:0] fall = ~cond_now & cond_prev_q;
  wire csu_mode_d = txrx_q[B_LINE_STD] & (timp_q[B_LBO_HI:0] >= LBO_CSU_FIRST);
  // open and short detection carry no meaning while a csu build-out is selected
  wire [3:0] func_gate = {1'b1, ~csu_mode_d, ~csu_mode_d, 1'b1};
  wire [7:0] latch_set = {fall, rise & func_gate};
  wire [7:0] latch_clr = (wr_reg && woff == 3'h5) ? wbyte_q : 8'h00;
  // set wins over a simultaneous write-one-to-clear so no event is lost
  wire [7:0] latched_d = (latched_q & ~latch_clr) | latch_set;
  wire irq_d = |(latched_d & mask_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched_q <= RST_REG;
    end else begin
      latched_q <= latched_d;
    end
  end

  // ---------------- derived line controls ----------------
  wire [7:0] rt_status = {2'b00, over_s, under_s, 1'b0, short_s, open_s, los_s};
  wire [1:0] ja_pos = txrx_q[B_JA_POS_HI:B_JA_POS_LO];
  wire [7:0] depth_d = txrx_q[B_JA_DEPTH] ? JA_DEPTH_SHALLOW : JA_DEPTH_DEEP;
  wire [1:0] crit_d = !txrx_q[B_LINE_STD] ? (txrx_q[B_LOS_CRIT] ? LOS_ETS300233 : LOS_G775)
                      : LOS_T1231;
  wire alarm_d = maint_q[B_FORCE_AIS] | (maint_q[B_AUTO_AIS] & los_s);
  // alarm ones beat far loopback data, which beats framer data
  wire line_data_d = alarm_d ? 1'b1 : (maint_q[B_FAR_LB] ? rx_line_data : framer_tx_data);
  // the pin has the last word: low pin floats the driver whatever software set
  wire oe_d = maint_q[B_DRV_ON] & txen_pin_s & ~maint_q[B_TX_PD];

  logic [7:0] depth_q;
  logic [1:0] crit_q;
  logic ja_rx_q, ja_tx_q, csu_q, alarm_q, line_data_q, oe_q, irq_q, term_on_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      depth_q <= JA_DEPTH_DEEP;
      crit_q <= LOS_G775;
      ja_rx_q <= 1'b1;
      ja_tx_q <= 1'b0;
      csu_q <= 1'b0;
      alarm_q <= 1'b0;
      line_data_q <= 1'b0;
      oe_q <= 1'b0;
      irq_q <= 1'b0;
      term_on_q <= 1'b1;
    end else begin
      depth_q <= depth_d;
      crit_q <= crit_d;
      ja_rx_q <= (ja_pos == JA_POS_RX);
      ja_tx_q <= (ja_pos == JA_POS_TX);
      csu_q <= csu_mode_d;
      alarm_q <= alarm_d;
      line_data_q <= line_data_d;
      oe_q <= oe_d;
      irq_q <= irq_d;
      term_on_q <= ~timp_q[B_TERM_OFF];
    end
  end

  // ---------------- read path ----------------
  logic [7:0] reg_rd;
  always_comb begin
    case (roff)
      3'h0: reg_rd = txrx_q;
      3'h1: reg_rd = timp_q;
      3'h2: reg_rd = maint_q;
      3'h3: reg_rd = rt_status;
      3'h4: reg_rd = mask_q;
      3'h5: reg_rd = latched_q;
      3'h6: reg_rd = {level_s, 4'h0};
      3'h7: reg_rd = rxcfg_q;
      default: reg_rd = 8'h00;
    endcase
  end
  // reserved words read zero and swallow writes
  wire [31:0] rdata_d = (rsel == SEL_REG) ? {24'h00_0000, reg_rd} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- outputs ----------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign jitter_fifo_depth = depth_q;
  assign ja_in_rx_path = ja_rx_q;
  assign ja_in_tx_path = ja_tx_q;
  assign line_standard_sel = txrx_q[B_LINE_STD];
  assign signal_absence_criterion = crit_q;
  assign tx_termination_on = term_on_q;
  assign tx_load_impedance = timp_q[B_IMPL_HI:B_IMPL_LO];
  assign tx_waveshape = {txrx_q[B_LINE_STD], timp_q[B_LBO_HI:0]};
  assign tx_csu_mode = csu_q;
  assign tx_alarm_active = alarm_q;
  assign tx_line_data = line_data_q;
  assign near_loopback_en = maint_q[B_NEAR_LB];
  assign analog_loopback_en = maint_q[B_ANALOG_LB];
  assign far_loopback_en = maint_q[B_FAR_LB];
  assign tx_powerdown = maint_q[B_TX_PD];
  assign rx_powerdown = maint_q[B_RX_PD];
  assign tx_line_oe = oe_q;
  assign rx_impedance_cfg = rxcfg_q[7:4];
  assign rx_sensitivity_cfg = rxcfg_q[3:0];
  assign irq = irq_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_write_done;
    do_write;
  endsequence
  sequence s_resp_up;
    s_axi_bvalid;
  endsequence

  a_write_resp_time: assert property (s_write_done |=> s_resp_up)
    else $error("write response not raised one cycle after write");
  a_read_resp_time: assert property (ar_fire |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not valid one cycle after address");
  a_depth_select: assert property (1'b1 |=> jitter_fifo_depth ==
      ($past(txrx_q[B_JA_DEPTH]) ? 8'h20 : 8'h80))
    else $error("jitter depth does not follow its control bit");
  a_ja_position: assert property ((ja_pos[1]) |=> !ja_in_rx_path && !ja_in_tx_path)
    else $error("attenuator used while bypass selected");
  a_los_crit: assert property (line_standard_sel |=> signal_absence_criterion == LOS_T1231)
    else $error("t1 mode must use t1.231 criterion");
  a_alarm_force: assert property (maint_q[B_FORCE_AIS] |=> tx_alarm_active && tx_line_data)
    else $error("forced alarm not sending ones");
  a_alarm_auto: assert property (maint_q[B_AUTO_AIS] && los_s |=> tx_alarm_active)
    else $error("auto alarm missing on loss of signal");
  a_far_loop: assert property (far_loopback_en && !alarm_d |=> tx_line_data == $past(rx_line_data))
    else $error("far loopback does not return receive data");
  a_tx_float: assert property (maint_q[B_TX_PD] || !txen_pin_s |=> !tx_line_oe)
    else $error("transmit driven while powered down or pin low");
  a_los_latch: assert property (los_s && !cond_prev_q[0] |=> latched_q[0])
    else $error("loss of signal rise not latched");
  a_irq_follow: assert property (|(latched_q & mask_q) && $stable(mask_q) |-> irq)
    else $error("unmasked latched event did not raise irq");
  a_irq_masked: assert property (~|(latched_q & mask_q) && $stable(mask_q) |-> !irq)
    else $error("irq raised with nothing unmasked");

  sequence s_clear_all;
    wr_reg && woff == 3'h5 && wbyte_q == 8'hFF && latch_set == 8'h00;
  endsequence

  a_term_select: assert property (1'b1 |=> tx_termination_on ==
      !$past(timp_q[B_TERM_OFF]))
    else $error("termination does not follow its off bit");
  a_oe_enable: assert property (maint_q[B_DRV_ON] && txen_pin_s && !maint_q[B_TX_PD]
      |=> tx_line_oe)
    else $error("transmit outputs not driven while enabled");
  a_latch_clear: assert property (s_clear_all |=> latched_q == 8'h00)
    else $error("latched status not cleared by write of ones");
  a_los_clear_seen: assert property (!los_s && cond_prev_q[0] |=> latched_q[4])
    else $error("loss of signal removal not latched");
  a_alarm_off: assert property (!maint_q[B_FORCE_AIS] && !(maint_q[B_AUTO_AIS] && los_s)
      |=> !tx_alarm_active)
    else $error("alarm sent with no cause");
  a_framer_path: assert property (!alarm_d && !far_loopback_en
      |=> tx_line_data == $past(framer_tx_data))
    else $error("framer data not passed to the line");

endmodule // lictl_regs

//--- lictl_line_model.sv
// behavioural model of the analog line side: detectors, level meter, receive data
module lictl_line_model (
  input wire logic aclk, // system clock
  input wire logic [5:0] cond_req, // {under,over,jalt,short,open,los} from the bench
  input wire logic [3:0] level_req, // receive level code from the bench
  output logic los_det, // loss of signal
  output logic tx_open_det, // transmit outputs open
  output logic tx_short_det, // transmit outputs shorted
  output logic ja_limit_trip, // attenuator limit trip
  output logic equalizer_over, // over equalized
  output logic equalizer_under, // under equalized
  output logic [3:0] rx_level, // receive level code
  output logic rx_line_data // recovered receive data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cond_q = 6'h00;
  logic [3:0] level_q = 4'h0;
  logic [2:0] pat_q = 3'h1;
  always @(posedge aclk) begin
    cond_q <= cond_req;
    level_q <= level_req;
    pat_q <= {pat_q[1:0], pat_q[2] ^ pat_q[1]};
  end
  assign los_det = cond_q[0];
  assign tx_open_det = cond_q[1];
  assign tx_short_det = cond_q[2];
  assign ja_limit_trip = cond_q[3];
  assign equalizer_over = cond_q[4];
  assign equalizer_under = cond_q[5];
  assign rx_level = level_q;
  // never constant, so a loopback path stuck at one level is seen
  assign rx_line_data = pat_q[0];
endmodule // lictl_line_model

//--- tb.sv
// self-checking bench for the line interface control register bank
module tb import lictl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, rx_level, rx_impedance_cfg, rx_sensitivity_cfg, tx_waveshape, level_req;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, signal_absence_criterion, tx_load_impedance;
  logic los_det, tx_open_det, tx_short_det, equalizer_over, equalizer_under, ja_limit_trip;
  logic tx_enable_pin, rx_line_data, ja_in_rx_path, ja_in_tx_path, line_standard_sel;
  logic tx_termination_on, tx_csu_mode, tx_alarm_active, tx_line_data, near_loopback_en;
  logic analog_loopback_en, far_loopback_en, tx_powerdown, rx_powerdown, tx_line_oe, irq;
  logic framer_tx_data = 1'b0;
  logic [7:0] jitter_fifo_depth, v8;
  logic [5:0] cond_req;
  logic rx_prev, fr_prev;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int lb;

  lictl_regs lictl_regs_i (.*);
  lictl_line_model lictl_line_model_i (.*);

  always #20 aclk = ~aclk;
  always @(posedge aclk) framer_tx_data <= ~framer_tx_data;
  // a hung handshake ends the run here
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  function automatic logic [15:0] ba(input logic [13:0] i);
    return {i, 2'b00};
  endfunction

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input string n,
                    input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(n, e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  initial begin
    // response readies stay high so back-to-back calls never toggle them in one step
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00101;
    s_axi_awaddr = 16'h0000;
    s_axi_araddr = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'h0;
    tx_enable_pin = 1'b0;
    cond_req = 6'h00;
    level_req = 4'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(ba(IDX_LINE_TXRX_CONTROL + 14'(i)), 0, "reset value");
    chk("reset depth", 32'(JA_DEPTH_DEEP), 32'(jitter_fifo_depth));
    chk("reset oe", 0, 32'(tx_line_oe));
    for (int v = 0; v < 32; v++) begin
      wr(ba(IDX_LINE_TXRX_CONTROL), 8'(v) | 8'hE0);
      rd(ba(IDX_LINE_TXRX_CONTROL), 32'(v), "txrx control");
      chk("depth", 32'(v[4] ? JA_DEPTH_SHALLOW : JA_DEPTH_DEEP), 32'(jitter_fifo_depth));
      chk("ja rx", 32'(v[3:2] == 2'h0), 32'(ja_in_rx_path));
      chk("ja tx", 32'(v[3:2] == 2'h1), 32'(ja_in_tx_path));
      chk("standard", 32'(v[1]), 32'(line_standard_sel));
      chk("los crit", v[1] ? LOS_T1231 : 32'(v[0]), 32'(signal_absence_criterion));
    end
    for (int s = 0; s < 2; s++) begin
      wr(ba(IDX_LINE_TXRX_CONTROL), 8'(s << 1));
      for (int j = 0; j < 64; j++) begin
        v8 = {1'b1, 3'(j >> 3), 1'b1, 3'(j)};
        wr(ba(IDX_TX_IMPEDANCE_PULSE_SHAPE), v8);
        rd(ba(IDX_TX_IMPEDANCE_PULSE_SHAPE), 32'(v8 & MASK_TXIMP), "impedance reg");
        chk("termination", 32'(!v8[6]), 32'(tx_termination_on));
        chk("load imp", 32'(v8[5:4]), 32'(tx_load_impedance));
        chk("waveshape", 32'({s[0], v8[2:0]}), 32'(tx_waveshape));
        chk("csu", 32'(s[0] && v8[2:0] >= 3'h5), 32'(tx_csu_mode));
      end
    end
    wr(ba(IDX_LINE_TXRX_CONTROL), 8'h00);
    wr(ba(IDX_TX_IMPEDANCE_PULSE_SHAPE), 8'h00);
    for (int p = 0; p < 2; p++) begin
      tx_enable_pin <= p[0];
      for (int v = 0; v < 256; v++) begin
        wr(ba(IDX_LINE_MAINTENANCE_CONTROL), 8'(v));
        rd(ba(IDX_LINE_MAINTENANCE_CONTROL), 32'(v), "maintenance");
        chk("near lb", 32'(v[5]), 32'(near_loopback_en));
        chk("analog lb", 32'(v[4]), 32'(analog_loopback_en));
        chk("far lb", 32'(v[3]), 32'(far_loopback_en));
        chk("tx pd", 32'(v[2]), 32'(tx_powerdown));
        chk("rx pd", 32'(v[1]), 32'(rx_powerdown));
        chk("line oe", 32'(v[0] && p[0] && !v[2]), 32'(tx_line_oe));
        chk("alarm", 32'(v[7]), 32'(tx_alarm_active));
        for (int k = 0; k < 3; k++) begin
          rx_prev = rx_line_data;
          fr_prev = framer_tx_data;
          @(posedge aclk);
          chk("tx data", 32'(v[7] ? 1'b1 : (v[3] ? rx_prev : fr_prev)), 32'(tx_line_data));
        end
      end
    end
    wr(ba(IDX_LINE_MAINTENANCE_CONTROL), 8'h00);
    for (int i = 0; i < 4; i++) begin
      lb = (i == 1) ? 2 : ((i == 2) ? 1 : i);
      wr(ba(IDX_LINE_STATUS_INTERRUPT_MASK), 8'(16 << lb));
      cond_req <= 6'(1 << i);
      repeat (8) @(posedge aclk);
      chk("irq masked", 0, 32'(irq));
      rd(ba(IDX_LINE_REALTIME_STATUS), i < 3 ? 32'(1 << i) : 0, "realtime");
      rd(ba(IDX_LINE_LATCHED_STATUS), 32'(1 << lb), "latched set");
      cond_req <= 6'h00;
      repeat (8) @(posedge aclk);
      chk("irq raised", 1, 32'(irq));
      rd(ba(IDX_LINE_LATCHED_STATUS), 32'(17 << lb), "latched removed");
      wr(ba(IDX_LINE_LATCHED_STATUS), 8'hFF);
      rd(ba(IDX_LINE_LATCHED_STATUS), 0, "latched cleared");
      chk("irq dropped", 0, 32'(irq));
    end
    wr(ba(IDX_LINE_TXRX_CONTROL), 8'h02);
    wr(ba(IDX_TX_IMPEDANCE_PULSE_SHAPE), 8'h05);
    cond_req <= 6'h06;
    repeat (8) @(posedge aclk);
    rd(ba(IDX_LINE_LATCHED_STATUS), 0, "csu gated");
    cond_req <= 6'h00;
    repeat (8) @(posedge aclk);
    rd(ba(IDX_LINE_LATCHED_STATUS), 32'h60, "csu removed");
    wr(ba(IDX_LINE_LATCHED_STATUS), 8'hFF);
    wr(ba(IDX_LINE_TXRX_CONTROL), 8'h00);
    wr(ba(IDX_TX_IMPEDANCE_PULSE_SHAPE), 8'h00);
    cond_req <= 6'h10;
    repeat (8) @(posedge aclk);
    rd(ba(IDX_LINE_REALTIME_STATUS), 32'h20, "over eq");
    cond_req <= 6'h20;
    repeat (8) @(posedge aclk);
    rd(ba(IDX_LINE_REALTIME_STATUS), 32'h10, "under eq");
    wr(ba(IDX_LINE_MAINTENANCE_CONTROL), 8'h40);
    cond_req <= 6'h01;
    repeat (8) @(posedge aclk);
    chk("auto alarm", 1, 32'(tx_alarm_active));
    cond_req <= 6'h00;
    repeat (8) @(posedge aclk);
    chk("auto alarm off", 0, 32'(tx_alarm_active));
    level_req <= 4'hD;
    wr(ba(IDX_RX_IMPEDANCE_SENSITIVITY), 8'hA5);
    rd(ba(IDX_RX_IMPEDANCE_SENSITIVITY), 32'hA5, "rx imp sens");
    chk("rx cfg", 32'h5A, 32'({rx_sensitivity_cfg, rx_impedance_cfg}));
    rd(ba(IDX_RX_SIGNAL_LEVEL), 32'hD0, "rx level");
    wr(ba(IDX_LINE_REALTIME_STATUS), 8'hFF);
    rd(ba(IDX_LINE_REALTIME_STATUS), 0, "read only");
    wr(ba(IDX_RESERVED_FIRST), 8'h00);
    wr(ba(IDX_RESERVED_LAST), 8'h00);
    rd(ba(IDX_RESERVED_LAST), 0, "reserved");
    rd(16'h4080, 0, "unmapped", RESP_SLVERR);
    wr(16'h0000, 8'h00, RESP_SLVERR);
    end_sim();
  end
endmodule // tb
